// ==== brc_pkg.sv ====
// package: offsets, field positions, reset values and state layout of the bridge window block
package brc_pkg;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_PREF_BASE_HIGH = 8'h28;
   localparam logic [7:0] OFS_PREF_LIMIT_HIGH = 8'h2C;
   localparam logic [7:0] OFS_IO_WINDOW_HIGH = 8'h30;
   localparam logic [7:0] OFS_CAP_POINTER = 8'h34;
   localparam logic [7:0] OFS_INTR_BRIDGE_CTL = 8'h3C;
   localparam logic [7:0] OFS_EVT_STATUS = 8'hF0;
   localparam logic [7:0] OFS_EVT_CLEAR = 8'hF4;
   localparam logic [7:0] OFS_EVT_ENABLE = 8'hF8;

   // ****************************************
   // reset and fixed values
   // ****************************************
   localparam logic [7:0] CAP_POINTER_VALUE = 8'h80;
   localparam logic [7:0] INTR_PIN_VALUE = 8'h00;
   localparam logic [31:0] RESET_WINDOW_HIGH = 32'h0000_0000;
   localparam logic [7:0] RESET_ROUTE_BYTE = 8'h00;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CTL_BIT_LSB = 16;
   localparam int CTL_PARITY_RESP = 0;
   localparam int CTL_SERR_FWD = 1;
   localparam int CTL_ALIAS_BLOCK = 2;
   localparam int EVT_PARITY = 0;
   localparam int EVT_SERR = 1;
   localparam int IO_LOW_BITS = 12;
   localparam int PREF_LOW_BITS = 20;

   // axi answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // register index from the decoder
   typedef enum logic [3:0] {
      REG_NONE = 4'h0,
      REG_PBASE = 4'h1,
      REG_PLIMIT = 4'h2,
      REG_IOWIN = 4'h3,
      REG_CAP = 4'h4,
      REG_INTCTL = 4'h5,
      REG_STS = 4'h6,
      REG_CLR = 4'h7,
      REG_IEN = 4'h8
   } brc_reg_t;

   // whole state of the block, registered as one word
   typedef struct packed {
      logic [31:0] pbase_hi;
      logic [31:0] plimit_hi;
      logic [15:0] iobase_hi;
      logic [15:0] iolimit_hi;
      logic [7:0] route_byte;
      logic [2:0] bctl;
      logic [1:0] sts;
      logic [1:0] ien;
      logic aw_held;
      logic w_held;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [2:0] serr_sync;
      logic serr_lvl;
      logic pref_hit;
      logic io_down;
      logic io_up;
      logic serr_fwd;
      logic par_report;
   } brc_state_t;

endpackage

// ==== brc_bridge_window.sv ====
// bridge window upper halves, capability pointer, interrupt bytes and low bridge control bits
//
// Behaviour
// - prefetch base high word, read/write, reset zero
// - prefetch limit high word, read/write, reset zero
// - io base high in bits 15:0
// - io limit high in bits 31:16
// - capability pointer read-only, reads 80h
// - routing byte writable, drives nothing
// - interrupt pin byte reads zero
// - parity response bit gates secondary parity errors
// - error forward bit gates forwarding of secondary system error, not its status bit or irq
// - alias filtering only inside window, below 64KB
// - filter off forwards whole io window
// - filter on blocks upper 768 bytes per 1KB
// - filter on forwards those addresses upstream
// - prefetch lower bound low bits zero
// - prefetch upper bound low bits ones
`timescale 1ns/1ps

module brc_bridge_window (
   input wire logic clk_sys,
   input wire logic rst_b,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // lower window halves from the neighbouring register block
   input wire logic [11:0] pref_base_low,
   input wire logic [11:0] pref_limit_low,
   input wire logic [3:0] io_base_low,
   input wire logic [3:0] io_limit_low,
   // forwarding queries
   input wire logic [63:0] mem_query_addr,
   input wire logic [31:0] io_down_addr,
   input wire logic [31:0] io_up_addr,
   output logic pref_window_hit,
   output logic io_forward_down,
   output logic io_forward_up,
   // secondary bus error sources
   input wire logic secondary_system_error_in_b,
   input wire logic sec_parity_error_in,
   output logic primary_system_error_req,
   output logic sec_parity_report,
   output logic legacy_alias_block_enable,
   output logic irq
);

   // ****************************************
   // decoding helpers
   // ****************************************

   // address to register index, shared by reads and writes
   function automatic brc_pkg::brc_reg_t reg_index(input logic [7:0] a);
      brc_pkg::brc_reg_t r;
      r = brc_pkg::REG_NONE;
      // low two address bits dropped, words are aligned
      unique case ({a[7:2], 2'b00})
         brc_pkg::OFS_PREF_BASE_HIGH: r = brc_pkg::REG_PBASE;
         brc_pkg::OFS_PREF_LIMIT_HIGH: r = brc_pkg::REG_PLIMIT;
         brc_pkg::OFS_IO_WINDOW_HIGH: r = brc_pkg::REG_IOWIN;
         brc_pkg::OFS_CAP_POINTER: r = brc_pkg::REG_CAP;
         brc_pkg::OFS_INTR_BRIDGE_CTL: r = brc_pkg::REG_INTCTL;
         brc_pkg::OFS_EVT_STATUS: r = brc_pkg::REG_STS;
         brc_pkg::OFS_EVT_CLEAR: r = brc_pkg::REG_CLR;
         brc_pkg::OFS_EVT_ENABLE: r = brc_pkg::REG_IEN;
         default: r = brc_pkg::REG_NONE;
      endcase
      return r;
   endfunction

   // per-byte merge of write data into an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] m;
      m = old;
      // lanes without a strobe keep the old byte
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return m;
   endfunction

   // ****************************************
   // state
   // ****************************************
   // every flop of the block lives in q
   brc_pkg::brc_state_t q; // registered state
   brc_pkg::brc_state_t d; // next state
   logic [63:0] pref_lo_bound; // formed 64-bit lower bound
   logic [63:0] pref_hi_bound; // formed 64-bit upper bound
   logic [31:0] io_lo_bound; // formed io lower bound
   logic [31:0] io_hi_bound; // formed io upper bound
   logic dn_in_win; // downstream address inside io window
   logic dn_filtered; // downstream address in alias region
   logic up_in_win; // upstream address inside io window
   logic up_filtered; // upstream address in alias region
   logic wr_fire; // both write halves held, response free
   logic rd_fire; // read address taken
   logic [31:0] wr_word; // word at write address before merge
   logic [31:0] rd_word; // word at read address
   brc_pkg::brc_reg_t wr_idx; // decoded write target
   brc_pkg::brc_reg_t rd_idx; // decoded read target
   logic [1:0] evt_set; // events this cycle
   logic [31:0] wr_merged; // write data merged into the old word
   logic [1:0] clr_bits; // status bits named by a clear write

   // ****************************************
   // window bounds
   // ****************************************

   assign pref_lo_bound = {q.pbase_hi, pref_base_low, {brc_pkg::PREF_LOW_BITS{1'b0}}};
   assign pref_hi_bound = {q.plimit_hi, pref_limit_low, {brc_pkg::PREF_LOW_BITS{1'b1}}};
   // io bounds: low bits zero below, ones above
   assign io_lo_bound = {q.iobase_hi, io_base_low, {brc_pkg::IO_LOW_BITS{1'b0}}};
   assign io_hi_bound = {q.iolimit_hi, io_limit_low, {brc_pkg::IO_LOW_BITS{1'b1}}};

   assign dn_in_win = (io_down_addr >= io_lo_bound) && (io_down_addr <= io_hi_bound);
   assign up_in_win = (io_up_addr >= io_lo_bound) && (io_up_addr <= io_hi_bound);

   // below 64KB, offset 100h..3FFh of each 1KB
   assign dn_filtered = dn_in_win && (io_down_addr[31:16] == 16'h0000) && (io_down_addr[9:8] != 2'h0);
   assign up_filtered = up_in_win && (io_up_addr[31:16] == 16'h0000) && (io_up_addr[9:8] != 2'h0);

   // ****************************************
   // bus decode
   // ****************************************
   // a write retires once both halves are in and no response waits
   assign wr_fire = q.aw_held && q.w_held && !q.bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign wr_idx = reg_index(q.awaddr);
   assign rd_idx = reg_index(s_axi_araddr);

   // current contents by register, for reads and write merging
   function automatic logic [31:0] reg_word(input brc_pkg::brc_reg_t r, input brc_pkg::brc_state_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (r)
         brc_pkg::REG_PBASE: w = s.pbase_hi;
         brc_pkg::REG_PLIMIT: w = s.plimit_hi;
         brc_pkg::REG_IOWIN: w = {s.iolimit_hi, s.iobase_hi};
         brc_pkg::REG_CAP: w = {24'h000000, brc_pkg::CAP_POINTER_VALUE};
         brc_pkg::REG_INTCTL: w = {13'h0, s.bctl, brc_pkg::INTR_PIN_VALUE, s.route_byte};
         brc_pkg::REG_STS: w = {30'h0, s.sts};
         brc_pkg::REG_IEN: w = {30'h0, s.ien};
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   assign rd_word = reg_word(rd_idx, q);
   assign wr_word = reg_word(wr_idx, q);

   // one merge feeds every register, strobes act alike
   assign wr_merged = merge(wr_word, q.wdata, q.wstrb);
   // clear mask follows the low byte strobe
   assign clr_bits = q.wdata[1:0] & {2{q.wstrb[0]}};

   // events: parity only when enabled, error on its asserting edge
   always_comb begin
      evt_set = 2'b00;
      evt_set[brc_pkg::EVT_PARITY] = sec_parity_error_in && q.bctl[brc_pkg::CTL_PARITY_RESP];
      // next level worked out from q, so no loop runs through d
      evt_set[brc_pkg::EVT_SERR] = (q.serr_sync[1] == q.serr_sync[2]) && q.serr_sync[2] && !q.serr_lvl;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      d = q;
      // write channel capture, either order
      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_held = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_held = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      // response leaves on the bready edge
      if (s_axi_bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      // answer and register update land on one edge
      if (wr_fire) begin
         d.aw_held = 1'b0;
         d.w_held = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = (wr_idx == brc_pkg::REG_NONE) ? brc_pkg::RESP_SLVERR : brc_pkg::RESP_OKAY;
         unique case (wr_idx)
            brc_pkg::REG_PBASE: d.pbase_hi = wr_merged;
            brc_pkg::REG_PLIMIT: d.plimit_hi = wr_merged;
            brc_pkg::REG_IOWIN: begin
               d.iobase_hi = wr_merged[15:0];
               d.iolimit_hi = wr_merged[31:16];
            end
            brc_pkg::REG_INTCTL: begin
               d.route_byte = wr_merged[7:0];
               // pin byte stays zero; fixed pin byte
               d.bctl = wr_merged[brc_pkg::CTL_BIT_LSB +: 3];
            end
            // event enables, low two bits only
            brc_pkg::REG_IEN: d.ien = wr_merged[1:0];
            // capability pointer and status ignore writes; read-only
            default: d.bresp = d.bresp;
         endcase
      end
      // read channel: one outstanding, data latched at acceptance
      if (s_axi_rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      // word taken as it stands at acceptance
      if (rd_fire) begin
         d.rvalid = 1'b1;
         d.rdata = rd_word;
         d.rresp = (rd_idx == brc_pkg::REG_NONE) ? brc_pkg::RESP_SLVERR : brc_pkg::RESP_OKAY;
      end
      // pin synchroniser, stored as asserted-high
      d.serr_sync = {q.serr_sync[1:0], ~secondary_system_error_in_b};
      // level moves only when the late stages agree; short glitches are lost
      if (q.serr_sync[1] == q.serr_sync[2]) begin
         d.serr_lvl = q.serr_sync[2];
      end
      // status: set wins over a clear in the same cycle
      if (wr_fire && (wr_idx == brc_pkg::REG_CLR)) begin
         d.sts = (q.sts & ~clr_bits) | evt_set;
      end else begin
         d.sts = q.sts | evt_set;
      end
      d.serr_fwd = d.serr_lvl && q.bctl[brc_pkg::CTL_SERR_FWD];
      d.par_report = evt_set[brc_pkg::EVT_PARITY];
      d.pref_hit = (mem_query_addr >= pref_lo_bound) && (mem_query_addr <= pref_hi_bound);
      // whole window when filter off; alias blocked when on
      d.io_down = dn_in_win && !(q.bctl[brc_pkg::CTL_ALIAS_BLOCK] && dn_filtered);
      // aliases go upstream when filter on
      d.io_up = !up_in_win || (q.bctl[brc_pkg::CTL_ALIAS_BLOCK] && up_filtered);
   end

   // ****************************************
   // state register
   // ****************************************
   // async clear from the bus reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         // every field, windows and bytes included, resets to zero
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // ready only when the holding slot is empty, which backs up the master
   assign s_axi_awready = !q.aw_held && !q.bvalid;
   assign s_axi_wready = !q.w_held && !q.bvalid;
   assign s_axi_arready = !q.rvalid;
   // responses straight from flops
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   // decisions registered, one edge behind the query
   assign pref_window_hit = q.pref_hit;
   assign io_forward_down = q.io_down;
   assign io_forward_up = q.io_up;
   assign primary_system_error_req = q.serr_fwd;
   assign sec_parity_report = q.par_report;
   // filter bit also goes out to the decoder
   assign legacy_alias_block_enable = q.bctl[brc_pkg::CTL_ALIAS_BLOCK];
   // level interrupt, dropped by the clear register or by clearing its enable bit
   assign irq = |(q.sts & q.ien);

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   AST_PBASE_WR: assert property (wr_fire && wr_idx == brc_pkg::REG_PBASE && q.wstrb == 4'hF
      |=> q.pbase_hi == $past(q.wdata)) else $error("prefetch base high not written");
   AST_PLIMIT_WR: assert property (wr_fire && wr_idx == brc_pkg::REG_PLIMIT && q.wstrb == 4'hF
      |=> q.plimit_hi == $past(q.wdata)) else $error("prefetch limit high not written");
   AST_IOBASE_SPLIT: assert property (wr_fire && wr_idx == brc_pkg::REG_IOWIN && q.wstrb == 4'h3
      |=> $stable(q.iolimit_hi) && q.iobase_hi == $past(q.wdata[15:0])) else $error("io base half wrong");
   AST_IOLIMIT_SPLIT: assert property (wr_fire && wr_idx == brc_pkg::REG_IOWIN && q.wstrb == 4'hC
      |=> $stable(q.iobase_hi) && q.iolimit_hi == $past(q.wdata[31:16])) else $error("io limit half wrong");
   AST_CAP_PTR: assert property (rd_fire && rd_idx == brc_pkg::REG_CAP
      |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0080) else $error("capability pointer not 80h");
   AST_PIN_ZERO: assert property (rd_fire && rd_idx == brc_pkg::REG_INTCTL
      |=> s_axi_rdata[15:8] == 8'h00 && s_axi_rdata[31:19] == 13'h0000) else $error("pin byte not zero");
   AST_PAR_IGNORE: assert property (!q.bctl[brc_pkg::CTL_PARITY_RESP]
      |=> !sec_parity_report) else $error("parity reported while ignored");
   AST_SERR_GATE: assert property (primary_system_error_req |-> $past(q.bctl[brc_pkg::CTL_SERR_FWD]))
      else $error("system error forwarded while disabled");
   AST_FWD_ALL: assert property (!q.bctl[brc_pkg::CTL_ALIAS_BLOCK] && dn_in_win
      |=> io_forward_down) else $error("in-window io not forwarded");
   AST_ALIAS_BLOCK: assert property (q.bctl[brc_pkg::CTL_ALIAS_BLOCK] && dn_filtered
      |=> !io_forward_down) else $error("alias address forwarded downstream");
   AST_HIGH_IO_PASS: assert property (q.bctl[brc_pkg::CTL_ALIAS_BLOCK] && dn_in_win && io_down_addr[31:16] != 16'h0
      |=> io_forward_down) else $error("filter applied above 64KB");
   AST_ALIAS_UP: assert property (q.bctl[brc_pkg::CTL_ALIAS_BLOCK] && up_filtered
      |=> io_forward_up) else $error("alias address not forwarded upstream");
   AST_PREF_BOUNDS: assert property (pref_lo_bound <= pref_hi_bound
      && (mem_query_addr == pref_lo_bound || mem_query_addr == pref_hi_bound) |=> pref_window_hit)
      else $error("window bound not inclusive");
   AST_ROUTE_WR: assert property (wr_fire && wr_idx == brc_pkg::REG_INTCTL && q.wstrb[0]
      |=> q.route_byte == $past(q.wdata[7:0])) else $error("routing byte not written");
   AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid) else $error("write response late");
   // window edges
   AST_PREF_BELOW: assert property (mem_query_addr < pref_lo_bound
      |=> !pref_window_hit) else $error("prefetch hit below lower bound");
   AST_PREF_ABOVE: assert property (mem_query_addr > pref_hi_bound
      |=> !pref_window_hit) else $error("prefetch hit above upper bound");
   AST_IO_OUTSIDE: assert property (!dn_in_win
      |=> !io_forward_down) else $error("io forwarded outside window");
   // events and read answers
   AST_PAR_REPORT: assert property (sec_parity_error_in && q.bctl[brc_pkg::CTL_PARITY_RESP]
      |=> sec_parity_report && q.sts[brc_pkg::EVT_PARITY]) else $error("parity error not reported");
   AST_SERR_STATUS: assert property (evt_set[brc_pkg::EVT_SERR]
      |=> q.sts[brc_pkg::EVT_SERR]) else $error("system error event not latched");
   AST_RD_UNMAPPED: assert property (rd_fire && rd_idx == brc_pkg::REG_NONE
      |=> s_axi_rresp == brc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   AST_RD_DATA: assert property (rd_fire && rd_idx == brc_pkg::REG_PBASE
      |=> s_axi_rdata == $past(q.pbase_hi)) else $error("read data not register contents");

   // ****************************************
   // cover points
   // ****************************************
   COV_WRITE: cover property (wr_fire && wr_idx == brc_pkg::REG_IOWIN);
   COV_ALIAS: cover property (q.bctl[brc_pkg::CTL_ALIAS_BLOCK] && dn_filtered);
   COV_SERR: cover property (primary_system_error_req ##1 irq);
   COV_PARITY: cover property (sec_parity_report);
   COV_READ_CAP: cover property (rd_fire && rd_idx == brc_pkg::REG_CAP);

endmodule

// ==== brc_sec_bus_model.sv ====
// secondary bus error source model for the bridge window bench
`timescale 1ns/1ps

module brc_sec_bus_model (
   input wire logic clk_sys,
   input wire logic serr_req,
   input wire logic par_req,
   output logic secondary_system_error_in_b,
   output logic sec_parity_error_in
);
   // pin has a pull-up, so a released line reads high
   initial begin
      secondary_system_error_in_b = 1'b1;
      sec_parity_error_in = 1'b0;
   end
   // error sources
   // launched on the edge so the block sees clean levels
   always @(posedge clk_sys) begin
      secondary_system_error_in_b <= !serr_req;
      sec_parity_error_in <= par_req;
   end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the bridge window register block
`timescale 1ns/1ps

module tb_top;
   logic clk_sys, rst_b;
   logic [7:0] awaddr, araddr;
   logic awvalid, wvalid, arvalid, awready, wready, arready, bvalid, rvalid;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [11:0] pbl, pll;
   logic [3:0] ibl, ill;
   logic [63:0] mem_query_addr;
   logic [31:0] io_down_addr, io_up_addr;
   logic pref_window_hit, io_forward_down, io_forward_up;
   logic serr_pin_b, par_in, serr_req, par_req;
   logic primary_system_error_req, sec_parity_report, legacy_alias_block_enable, irq;
   int mismatches, n_compared, par_cnt, serr_cnt;

   brc_bridge_window uut (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1), .pref_base_low(pbl), .pref_limit_low(pll), .io_base_low(ibl), .io_limit_low(ill),
      .mem_query_addr(mem_query_addr), .io_down_addr(io_down_addr), .io_up_addr(io_up_addr),
      .pref_window_hit(pref_window_hit), .io_forward_down(io_forward_down), .io_forward_up(io_forward_up),
      .secondary_system_error_in_b(serr_pin_b), .sec_parity_error_in(par_in),
      .primary_system_error_req(primary_system_error_req), .sec_parity_report(sec_parity_report),
      .legacy_alias_block_enable(legacy_alias_block_enable), .irq(irq));

   brc_sec_bus_model sec (.clk_sys(clk_sys), .serr_req(serr_req), .par_req(par_req),
      .secondary_system_error_in_b(serr_pin_b), .sec_parity_error_in(par_in));

   // 25 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // pulse counters, sampled on the edge like the block does
   always @(posedge clk_sys) begin
      if (sec_parity_report === 1'b1) par_cnt++;
      if (primary_system_error_req === 1'b1) serr_cnt++;
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // bready is held high throughout, so only the request halves move
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      int n;
      logic b;
      n = 0;
      b = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!b && n < 100) begin
         @(posedge clk_sys);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            b = 1'b1;
            chk("bresp", er, bresp);
         end
      end
      if (!b) chk("bvalid", 1, 0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      logic g;
      n = 0;
      g = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!g && n < 100) begin
         @(posedge clk_sys);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            g = 1'b1;
            chk("rdata", ed, rdata);
            chk("rresp", er, rresp);
         end
      end
      if (!g) chk("rvalid", 1, 0);
   endtask

   // decision outputs land one edge after the query, read at the next edge while held
   task automatic qry(input logic [63:0] m, input logic [31:0] io, input logic [2:0] e);
      mem_query_addr <= m;
      io_down_addr <= io;
      io_up_addr <= io;
      tick(2);
      chk("hit_down_up", e, {pref_window_hit, io_forward_down, io_forward_up});
   endtask

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // hang guard, far beyond the expected run of under 1000 cycles
   initial begin
      #(40 * 5000);
      mismatches++;
      print_verdict;
   end

   // ****************************************
   // tests
   // ****************************************
   initial begin
      {awaddr, araddr, wdata, wstrb, awvalid, wvalid, arvalid} = '0;
      {pbl, pll, ibl, ill, mem_query_addr, io_down_addr, io_up_addr} = '0;
      {serr_req, par_req, mismatches, n_compared, par_cnt, serr_cnt} = '0;
      rst_b = 1'b0;
      tick(4);
      rst_b <= 1'b1;
      // reset values and access kinds
      rd(8'h28, 32'h0, 2'h0);
      rd(8'h2C, 32'h0, 2'h0);
      rd(8'h30, 32'h0, 2'h0);
      rd(8'h34, 32'h80, 2'h0);
      rd(8'h3C, 32'h0, 2'h0);
      wr(8'h28, 32'hA5A5_5A5A, 4'hF, 2'h0);
      rd(8'h28, 32'hA5A5_5A5A, 2'h0);
      wr(8'h2C, 32'h1234_5678, 4'hF, 2'h0);
      rd(8'h2C, 32'h1234_5678, 2'h0);
      wr(8'h30, 32'h1234_5678, 4'h3, 2'h0);
      rd(8'h30, 32'h0000_5678, 2'h0);
      wr(8'h30, 32'hABCD_0000, 4'hC, 2'h0);
      rd(8'h30, 32'hABCD_5678, 2'h0);
      wr(8'h34, 32'h0000_0011, 4'hF, 2'h0);
      rd(8'h34, 32'h80, 2'h0);
      wr(8'h3C, 32'hFFFF_FFFF, 4'h1, 2'h0);
      rd(8'h3C, 32'h0000_00FF, 2'h0);
      wr(8'h40, 32'h1, 4'hF, 2'h2);
      rd(8'h40, 32'h0, 2'h2);
      $display("test registers done");
      // prefetch window 1_12300000 .. 1_124FFFFF
      wr(8'h28, 32'h1, 4'hF, 2'h0);
      wr(8'h2C, 32'h1, 4'hF, 2'h0);
      pbl <= 12'h123;
      pll <= 12'h124;
      qry(64'h1_1230_0000, 32'h0, 3'h5);
      qry(64'h1_122F_FFFF, 32'h0, 3'h1);
      qry(64'h1_124F_FFFF, 32'h0, 3'h5);
      qry(64'h1_1250_0000, 32'h0, 3'h1);
      qry(64'h0_1230_0000, 32'h0, 3'h1);
      // io window 1000 .. 2FFF, filter off then on
      wr(8'h30, 32'h0, 4'hF, 2'h0);
      ibl <= 4'h1;
      ill <= 4'h2;
      qry(64'h0, 32'h1100, 3'h2);
      qry(64'h0, 32'h2FFF, 3'h2);
      qry(64'h0, 32'h0FFF, 3'h1);
      qry(64'h0, 32'h3000, 3'h1);
      wr(8'h3C, 32'h0004_0000, 4'h4, 2'h0);
      chk("alias_en", 1, legacy_alias_block_enable);
      qry(64'h0, 32'h1100, 3'h1);
      qry(64'h0, 32'h13FF, 3'h1);
      qry(64'h0, 32'h1000, 3'h2);
      qry(64'h0, 32'h14FF, 3'h2);
      wr(8'h30, 32'h0001_0001, 4'hF, 2'h0);
      qry(64'h0, 32'h1_1100, 3'h2);
      $display("test windows done");
      // parity ignored, then reported with status and interrupt
      par_req <= 1'b1;
      tick(1);
      par_req <= 1'b0;
      tick(4);
      chk("par_cnt", 0, par_cnt);
      rd(8'hF0, 32'h0, 2'h0);
      wr(8'h3C, 32'h0001_0000, 4'h4, 2'h0);
      par_req <= 1'b1;
      tick(1);
      par_req <= 1'b0;
      tick(4);
      chk("par_cnt", 1, par_cnt);
      rd(8'hF0, 32'h1, 2'h0);
      wr(8'hF8, 32'h3, 4'hF, 2'h0);
      chk("irq", 1, irq);
      wr(8'hF4, 32'h1, 4'hF, 2'h0);
      rd(8'hF0, 32'h0, 2'h0);
      chk("irq", 0, irq);
      $display("test parity done");
      // system error suppressed, then forwarded
      serr_req <= 1'b1;
      tick(10);
      chk("serr_cnt", 0, serr_cnt);
      rd(8'hF0, 32'h2, 2'h0);
      chk("irq", 1, irq);
      serr_req <= 1'b0;
      wr(8'hF4, 32'h2, 4'hF, 2'h0);
      wr(8'h3C, 32'h0002_0000, 4'h4, 2'h0);
      chk("irq", 0, irq);
      serr_req <= 1'b1;
      tick(10);
      chk("serr_fwd", 1, primary_system_error_req);
      serr_req <= 1'b0;
      tick(10);
      chk("serr_fwd", 0, primary_system_error_req);
      $display("test system error done");
      print_verdict;
   end
endmodule
